// ---- rtl/clock_input_routing_config.sv ----
// Clock input routing, pre-divider and loop power configuration with Avalon-MM slave
//
// Functional notes
// [RL1] Loop power code 01 holds loop powered down
// [RL2] Loop power code 00 runs loop normally
// [RL3] Bypass bit selects direct feed over pre-divider
// [RL4] Reset loads loop off, divide four, no bypass
// [RL5] Pre-divider supports ratios two through six
// [RL6] Polarity bit zero positive, one negative
// [RL7] Settings apply only after update write 0x01
// [RL8] Source select zero uses external clock pins
// [RL9] Software enables loop when oscillator used
// [RL10] Software programs loop range before use
// [RL11] Pre-divider path divides by at least two
// [RL12] Loop on with pre-divider feeds prescaler directly
// [RL13] Registers eight bits; other fields only stored
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module clock_input_routing_config
  import clkcfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic extClkIn,
  input wire logic altClkIn,
  output logic loopPowerDown,
  output logic loopEnable,
  output logic pfdNegative,
  output logic distClk,
  output logic prescalerClk
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hitsReg(input logic [ADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0] idx);
    hitsReg = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : hitsReg

  logic [7:0] loopCtrl_ff;
  logic [7:0] prediv_ff;
  logic [7:0] route_ff;
  route_cfg_t active_ff;
  route_cfg_t nxt_active;
  logic [31:0] nxt_readdata;
  logic [7:0] readByte;
  logic [7:0] statusByte;
  logic request;
  logic accept;
  logic wrAccept;
  logic lowLane;
  logic hitLoop;
  logic hitPrediv;
  logic hitRoute;
  logic hitUpdate;
  logic hitStatus;
  logic applyUpdate;

  assign request = read | write;
  // A request completes at the edge where waitrequest is seen low
  assign accept = request & ~waitrequest;
  assign lowLane = byteenable[0];
  assign wrAccept = accept & write & lowLane;
  assign hitLoop = hitsReg(address, LOOP_CTRL_IDX);
  assign hitPrediv = hitsReg(address, PREDIV_IDX);
  assign hitRoute = hitsReg(address, ROUTE_IDX);
  assign hitUpdate = hitsReg(address, UPDATE_IDX);
  assign hitStatus = hitsReg(address, STATUS_IDX);
  assign applyUpdate = wrAccept & hitUpdate & (writedata[7:0] == UPDATE_KEY); // see [RL7]

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, then a single low cycle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(request & waitrequest);
    end
  end

  // ----------------------------------------------------------------
  // Programmed registers, all eight bits kept as written
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      loopCtrl_ff <= LOOP_CTRL_RST; // see [RL4]
      prediv_ff <= PREDIV_RST; // see [RL4]
      route_ff <= ROUTE_RST; // see [RL4]
    end else begin
      if (wrAccept && hitLoop) begin
        loopCtrl_ff <= writedata[7:0]; // see [RL13]
      end
      if (wrAccept && hitPrediv) begin
        prediv_ff <= writedata[7:0]; // see [RL13]
      end
      if (wrAccept && hitRoute) begin
        route_ff <= writedata[7:0]; // see [RL13]
      end
    end
  end

  // ----------------------------------------------------------------
  // Live settings, copied only on the update write
  // ----------------------------------------------------------------
  // Only named fields are copied, so unnamed bits never reach routing
  assign nxt_active = '{
    loopPower: loopCtrl_ff[LOOP_PWR_LSB +: 2],
    pfdNegative: loopCtrl_ff[PFD_POL_BIT],
    ratioCode: prediv_ff[RATIO_LSB +: 3],
    bypass: route_ff[BYPASS_BIT],
    srcAlt: route_ff[SRC_SEL_BIT]
  }; // see [RL13]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_ff <= ROUTE_CFG_RST; // see [RL4]
    end else if (applyUpdate) begin
      active_ff <= nxt_active; // see [RL7]
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign statusByte = {active_ff.pfdNegative, active_ff.srcAlt, active_ff.bypass,
                       active_ff.ratioCode, active_ff.loopPower};
  // Update register reads zero: it acts only as a trigger
  assign readByte = hitLoop ? loopCtrl_ff :
                    hitPrediv ? prediv_ff :
                    hitRoute ? route_ff :
                    hitStatus ? statusByte : 8'h00;
  assign nxt_readdata = (request & waitrequest & read) ? {24'h000000, readByte} : readdata;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h00000000;
    end else begin
      readdata <= nxt_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Clock path: source select, pre-divider, bypass
  // ----------------------------------------------------------------
  logic [1:0] pinsSynced;
  logic srcClk;
  logic divClk;
  logic loopOn;
  logic loopOff;
  logic nxt_distClk;
  logic nxt_prescalerClk;

  // The clock pins are sampled, so this path is a functional model of routing only
  pin_sync #(
    .WIDTH(2)
  ) u_pinSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn({altClkIn, extClkIn}),
    .syncOut(pinsSynced)
  );

  assign srcClk = active_ff.srcAlt ? pinsSynced[1] : pinsSynced[0]; // see [RL8]

  pre_divider u_preDivider (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkSample(srcClk),
    .ratioCode(active_ff.ratioCode), // see [RL5]
    .divOut(divClk)
  );

  assign loopOn = (active_ff.loopPower == PWR_NORMAL); // see [RL2]
  // Codes 10 and 11 also keep the loop idle; only 01 is the asynchronous power-down
  assign loopOff = (active_ff.loopPower == PWR_ASYNC_DOWN); // see [RL1]
  // Divide-by-one exists only through the bypass route
  assign nxt_distClk = active_ff.bypass ? srcClk : divClk; // see [RL3] [RL11]
  assign nxt_prescalerClk = loopOn & ~active_ff.bypass & srcClk; // see [RL12]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      loopPowerDown <= 1'b1;
      loopEnable <= 1'b0;
      pfdNegative <= 1'b0;
      distClk <= 1'b0;
      prescalerClk <= 1'b0;
    end else begin
      loopPowerDown <= loopOff; // see [RL1]
      loopEnable <= loopOn; // see [RL2]
      pfdNegative <= active_ff.pfdNegative; // see [RL6]
      distClk <= nxt_distClk;
      prescalerClk <= nxt_prescalerClk;
    end
  end

endmodule : clock_input_routing_config

// ---- rtl/clkcfg_pkg.sv ----
// Shared constants and types for the clock input routing configuration block
package clkcfg_pkg;

  // ----------------------------------------------------------------
  // Register map: register index, byte address is four times index
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] LOOP_CTRL_IDX = 10'h010;
  localparam logic [IDX_W-1:0] PREDIV_IDX = 10'h1e0;
  localparam logic [IDX_W-1:0] ROUTE_IDX = 10'h1e1;
  localparam logic [IDX_W-1:0] UPDATE_IDX = 10'h232;
  localparam logic [IDX_W-1:0] STATUS_IDX = 10'h233;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LOOP_PWR_LSB = 0;
  localparam int PFD_POL_BIT = 7;
  localparam int RATIO_LSB = 0;
  localparam int BYPASS_BIT = 0;
  localparam int SRC_SEL_BIT = 1;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_ASYNC_DOWN = 2'h1;
  localparam logic [2:0] RATIO_MAX_CODE = 3'h4;
  localparam logic [2:0] RATIO_BASE = 3'h2;
  localparam logic [7:0] UPDATE_KEY = 8'h01;
  localparam logic [7:0] LOOP_CTRL_RST = 8'h01;
  localparam logic [7:0] PREDIV_RST = 8'h02;
  localparam logic [7:0] ROUTE_RST = 8'h00;

  // Settings that are live in the routing logic
  typedef struct packed {
    logic [1:0] loopPower;
    logic pfdNegative;
    logic [2:0] ratioCode;
    logic bypass;
    logic srcAlt;
  } route_cfg_t;

  localparam route_cfg_t ROUTE_CFG_RST = '{
    loopPower: PWR_ASYNC_DOWN,
    pfdNegative: 1'b0,
    ratioCode: 3'h2,
    bypass: 1'b0,
    srcAlt: 1'b0
  };

endpackage : clkcfg_pkg

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_ff <= '0;
      syncOut <= '0;
    end else begin
      stage1_ff <= pinIn;
      syncOut <= stage1_ff;
    end
  end

endmodule : pin_sync

// ---- rtl/pre_divider.sv ----
// Selectable integer pre-divider on the sampled clock input
`timescale 1ns/1ps
module pre_divider
  import clkcfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkSample,
  input wire logic [2:0] ratioCode,
  output logic divOut
);

  logic prev_ff;
  logic [2:0] count_ff;
  logic [2:0] nxt_count;
  logic [2:0] ratio;
  logic [2:0] halfRatio;
  logic risingEdge;

  // Codes above the top ratio clamp to it; the smallest ratio is two
  assign ratio = (ratioCode > RATIO_MAX_CODE) ? (RATIO_MAX_CODE + RATIO_BASE)
                                              : (ratioCode + RATIO_BASE); // see [RL5] [RL11]
  assign halfRatio = ratio >> 1;
  assign risingEdge = clkSample & ~prev_ff;
  assign nxt_count = (count_ff >= ratio - 3'h1) ? 3'h0 : count_ff + 3'h1;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b0;
      count_ff <= 3'h0;
      divOut <= 1'b0;
    end else begin
      prev_ff <= clkSample;
      if (risingEdge) begin
        count_ff <= nxt_count;
        divOut <= (nxt_count < halfRatio);
      end
    end
  end

endmodule : pre_divider

// ---- test/clock_input_routing_config_sva.sv ----
// Checker for bus timing, update gating and loop outputs of the routing block
`timescale 1ns/1ps
module clock_input_routing_config_chk
  import clkcfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic loopPowerDown,
  input wire logic loopEnable,
  input wire logic pfdNegative,
  input wire logic prescalerClk
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Only a keyed update write may move the live loop outputs
  wire updOk = write && !waitrequest && address == 12'h8c8 && byteenable[0]
    && writedata[7:0] == 8'h01;
  sequence reqWaiting;
    (read || write) && waitrequest;
  endsequence
  sequence loopOff;
    !loopEnable [*8];
  endsequence
  property unmappedZero;
    reqWaiting ##0 (read && address[1:0] != 2'h0) |=> readdata == 32'h0;
  endproperty
  property resetDefaults;
    $fell(rst) |-> loopPowerDown && !loopEnable && !pfdNegative;
  endproperty
  // Live settings move at the completing edge, the outputs one edge later
  property updateGate;
    $changed(loopEnable) || $changed(loopPowerDown) || $changed(pfdNegative)
      |-> $past(updOk, 2);
  endproperty
  a_wait_answer: assert property (reqWaiting |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_once: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero: assert property (unmappedZero)
    else $error("unaligned read returned data");
  a_upper_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_power_excl: assert property (!(loopPowerDown && loopEnable))
    else $error("loop both powered down and enabled");
  a_reset_dflt: assert property (resetDefaults)
    else $error("loop outputs not at defaults after reset");
  a_update_gate: assert property (updateGate)
    else $error("loop output changed without update write");
  a_presc_off: assert property (loopOff |-> !prescalerClk)
    else $error("prescaler clock runs with loop off");
endmodule : clock_input_routing_config_chk
bind clock_input_routing_config clock_input_routing_config_chk u_chk (.ref_clk(ref_clk), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .loopPowerDown(loopPowerDown),
  .loopEnable(loopEnable), .pfdNegative(pfdNegative), .prescalerClk(prescalerClk));

// ---- test/tb_clock_input_routing_config.sv ----
// Self-checking testbench for the clock input routing block
`timescale 1ns/1ps
module tb_clock_input_routing_config
  import clkcfg_pkg::*;
;
  logic ref_clk = 0, rst = 1, read = 0, write = 0, extClkIn = 0, altClkIn = 0;
  logic [ADDR_W-1:0] address = '0;
  logic [31:0] writedata = '0, readdata, r;
  logic [3:0] byteenable = 4'hf;
  logic waitrequest, loopPowerDown, loopEnable, pfdNegative, distClk, prescalerClk;
  logic [7:0] d;
  logic [7:0] q[$];
  int num_errors = 0, check_count = 0, ec = 0, p;
  clock_input_routing_config u_dut (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .extClkIn(extClkIn), .altClkIn(altClkIn),
    .loopPowerDown(loopPowerDown), .loopEnable(loopEnable), .pfdNegative(pfdNegative),
    .distClk(distClk), .prescalerClk(prescalerClk));
  always #12.5 ref_clk = ~ref_clk;
  // Pin clocks of period 4 and 6, slow enough for the input synchroniser
  always @(posedge ref_clk) begin
    ec <= ec + 1;
    extClkIn <= (ec % 4) < 2;
    altClkIn <= (ec % 6) < 3;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("errors %0d, checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] dv, input logic be);
    int n = 0;
    logic [31:0] rv;
    rv = $urandom();
    @(posedge ref_clk);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= {rv[23:0], dv};
    byteenable <= {3'h7, be};
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      num_errors++;
      test_done();
    end
    read <= 0;
    write <= 0;
  endtask : bus
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    q.push_back(e);
    bus(0, a, 8'h00, 1);
  endtask : rd
  task automatic upd(input logic [11:0] a, input logic [7:0] dv);
    bus(1, a, dv, 1);
    bus(1, 12'h8c8, 8'h01, 1);
  endtask : upd
  function automatic logic sig(input logic w);
    return w ? prescalerClk : distClk;
  endfunction : sig
  // Period in ref_clk cycles between two rises of the chosen clock output
  task automatic period(input logic w, output int pc);
    int n = 0;
    int t0 = 0;
    repeat (40) @(posedge ref_clk);
    repeat (2) begin
      while (sig(w) !== 1'b0 && n < 400) begin
        @(posedge ref_clk);
        n++;
      end
      while (sig(w) !== 1'b1 && n < 400) begin
        @(posedge ref_clk);
        n++;
      end
      pc = n - t0;
      t0 = n;
    end
    if (n >= 400) begin
      num_errors++;
      test_done();
    end
  endtask : period
  always @(posedge ref_clk) if (read && waitrequest === 1'b0 && q.size() > 0) begin
    check("readdata", readdata, {24'h0, q.pop_front()});
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    test_done();
  end
  initial begin
    void'($urandom(31392));
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    @(negedge ref_clk);
    check("loopPowerDown", loopPowerDown, 1);
    check("loopEnable", loopEnable, 0);
    check("pfdNegative", pfdNegative, 0);
    rd(12'h040, 8'h01);
    rd(12'h780, 8'h02);
    rd(12'h784, 8'h00);
    rd(12'h8cc, 8'h09);
    // Software turns the loop on and sets its polarity before the keyed update
    bus(1, 12'h040, 8'h80, 1);
    bus(1, 12'h8c8, 8'h02, 1);
    repeat (3) @(negedge ref_clk);
    check("loopEnable", loopEnable, 0);
    rd(12'h040, 8'h80);
    bus(1, 12'h8c8, 8'h01, 1);
    repeat (3) @(negedge ref_clk);
    check("loopEnable", loopEnable, 1);
    check("pfdNegative", pfdNegative, 1);
    rd(12'h8cc, 8'h88);
    bus(1, 12'h784, 8'h03, 0);
    rd(12'h784, 8'h00);
    bus(1, 12'h004, 8'hff, 1);
    rd(12'h004, 8'h00);
    rd(12'h041, 8'h00);
    for (int c = 0; c < 5; c++) begin
      r = $urandom();
      d = {r[7:3], 3'(c)};
      upd(12'h780, d);
      rd(12'h780, d);
      period(0, p);
      check("distClk period", p, 4 * (c + 2));
    end
    // Ratio codes above the top one clamp to divide by six
    upd(12'h780, 8'h07);
    period(0, p);
    check("clamped period", p, 24);
    period(1, p);
    check("prescalerClk period", p, 4);
    upd(12'h784, 8'h01);
    period(0, p);
    check("bypass period", p, 4);
    check("prescalerClk", prescalerClk, 0);
    upd(12'h784, 8'h03);
    period(0, p);
    check("alt source period", p, 6);
    upd(12'h784, 8'h01);
    period(0, p);
    check("ext source period", p, 4);
    upd(12'h040, 8'h01);
    repeat (3) @(negedge ref_clk);
    check("loopPowerDown", loopPowerDown, 1);
    check("pfdNegative", pfdNegative, 0);
    upd(12'h040, 8'h02);
    repeat (3) @(negedge ref_clk);
    check("loopPowerDown code 10", loopPowerDown, 0);
    check("loopEnable code 10", loopEnable, 0);
    // Reset in mid-run restores both the stored and the live settings
    @(posedge ref_clk);
    rst <= 1;
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    @(negedge ref_clk);
    check("loopPowerDown after reset", loopPowerDown, 1);
    check("loopEnable after reset", loopEnable, 0);
    rd(12'h784, 8'h00);
    rd(12'h8cc, 8'h09);
    test_done();
  end
endmodule : tb_clock_input_routing_config
